// ### sim/core_model.sv
`timescale 1ns/10ps
// ----------
// core side: 16-bit accesses and page writes
// ----------
module core_model (
	// clock
	input wire logic clk_i,
	// access
	output logic [15:0] addr_o = 16'h0,
	output logic valid_o = 1'b0,
	output logic dbg_o = 1'b0,
	// writes
	output logic [2:0] pwe_o = 3'h0,
	output logic [7:0] wdata_o = 8'h0,
	output logic enwe_o = 1'b0,
	output logic [2:0] endata_o = 3'h0,
	output logic mwe_o = 1'b0,
	output logic [2:0] msel_o = 3'h0,
	output logic [15:0] mdata_o = 16'h0
);
	task automatic acc(input logic [15:0] a, input logic d);
		@(posedge clk_i);
		addr_o <= a;
		valid_o <= 1'b1;
		dbg_o <= d;
		@(posedge clk_i);
		// a released bus must not keep its last value
		addr_o <= ~a;
		valid_o <= 1'b0;
	endtask
	// k 0: call/return page, 1..2: plain store, 3: enables, 4+: map
	task automatic put(input int k, input logic [15:0] v);
		@(posedge clk_i);
		pwe_o <= (k < 3) ? 3'(1 << k) : 3'h0;
		enwe_o <= (k == 3);
		mwe_o <= (k > 3);
		msel_o <= 3'(k - 4);
		wdata_o <= v[7:0];
		endata_o <= v[2:0];
		mdata_o <= v;
		@(posedge clk_i);
		pwe_o <= 3'h0;
		enwe_o <= 1'b0;
		mwe_o <= 1'b0;
		wdata_o <= ~v[7:0];
		mdata_o <= ~v;
	endtask
endmodule // core_model

// ### sim/tb.sv
`timescale 1ns/10ps
// ----------
// self-checking bench
// ----------
module tb import page_map_pkg::*; ();
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [15:0] addr, mdata;
	logic [15:0] reg_b = 16'h0000;
	logic [15:0] ram_b = 16'h0800;
	logic valid, dbg, enwe, mwe, xvalid;
	logic [2:0] pwe, endata, msel, sel;
	logic [2:0] en = 3'h0;
	logic [7:0] wdata, program_page_select;
	logic [7:0] pp = 8'h0, dp = 8'h0, ep = 8'h0;
	logic [21:0] xaddr;
	logic [31:0] r;
	logic ce = 1'b1;
	logic xvalid_r;
	logic [2:0] sel_r;
	logic [7:0] program_page_select_r;
	logic [21:0] xaddr_r;
	int checks = 0;
	int n_mismatch = 0;
	integer seed = 32'h149b;

	always #4 clk = ~clk;

	core_model i_core_model (.clk_i(clk), .addr_o(addr), .valid_o(valid),
		.dbg_o(dbg), .pwe_o(pwe), .wdata_o(wdata), .enwe_o(enwe),
		.endata_o(endata), .mwe_o(mwe), .msel_o(msel), .mdata_o(mdata));
	paged_memory_window_map i_paged_memory_window_map (.CLK_I(clk),
		.NRST_I(nrst), .CE_I(ce), .ADDR_I(addr), .VALID_I(valid),
		.DEBUG_ACTIVE_I(dbg), .PROG_PAGE_WE_I(pwe[0]),
		.DATA_PAGE_WE_I(pwe[1]), .EXTRA_PAGE_WE_I(pwe[2]),
		.PAGE_WDATA_I(wdata), .ENABLE_WE_I(enwe), .ENABLE_WDATA_I(endata),
		.MAP_WE_I(mwe), .MAP_SEL_I(msel), .MAP_WDATA_I(mdata),
		.XADDR_O(xaddr), .SEL_O(sel), .XVALID_O(xvalid), .PROG_PAGE_O(program_page_select));
	// reduced variant on the same stimulus: 6-bit program page only
	paged_memory_window_map #(.FULL_VARIANT(1'b0))
		i_paged_memory_window_map_r (.CLK_I(clk),
		.NRST_I(nrst), .CE_I(ce), .ADDR_I(addr), .VALID_I(valid),
		.DEBUG_ACTIVE_I(dbg), .PROG_PAGE_WE_I(pwe[0]),
		.DATA_PAGE_WE_I(pwe[1]), .EXTRA_PAGE_WE_I(pwe[2]),
		.PAGE_WDATA_I(wdata), .ENABLE_WE_I(enwe), .ENABLE_WDATA_I(endata),
		.MAP_WE_I(mwe), .MAP_SEL_I(msel), .MAP_WDATA_I(mdata),
		.XADDR_O(xaddr_r), .SEL_O(sel_r), .XVALID_O(xvalid_r),
		.PROG_PAGE_O(program_page_select_r));

	// later tests win, so they run from lowest to highest rank
	function automatic logic [24:0] exp_of(input logic [15:0] a,
		input logic d, input logic full);
		logic [2:0] s;
		logic [21:0] x;
		s = SEL_NONE;
		x = {6'h3f, a};
		if (full && en[2] && a[15:10] == 6'h01) begin
			s = SEL_WINDOW;
			x = {4'h0, ep, a[9:0]};
		end
		if (full && en[1] && a[15:12] == 4'h7) begin
			s = SEL_WINDOW;
			x = {2'h0, dp, a[11:0]};
		end
		if (en[0] && a[15:14] == 2'h2) begin
			s = SEL_WINDOW;
			x = {full ? pp : {2'h0, pp[5:0]}, a[13:0]};
		end
		if (a >= 16'hc000) s = SEL_FLASH;
		if (a[15:12] == 4'h1) s = SEL_EE;
		if (a >= ram_b && a - ram_b < 16'h0400) s = SEL_RAM;
		if (a >= (d ? 16'hff00 : 16'hff80)) s = SEL_VECT;
		if (a >= reg_b && a - reg_b < 16'h0200) s = SEL_REGS;
		if (s != SEL_WINDOW) x = {6'h3f, a};
		return {s, x};
	endfunction

	task automatic chk(input logic [33:0] seen, input logic [33:0] want);
		checks++;
		if (seen !== want) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask

	task automatic put(input int k, input logic [15:0] v);
		i_core_model.put(k, v);
		if (k == 0) pp = v[7:0];
		if (k == 1) dp = v[7:0];
		if (k == 2) ep = v[7:0];
		if (k == 3) en = v[2:0];
		if (k == 4) reg_b = v;
		if (k == 5) ram_b = v;
	endtask

	// both variants, each against the expected map of its own variant
	task automatic both(input logic [15:0] a, input logic d, input logic v);
		logic [33:0] w;
		w = {v, 2'h0, pp[5:0], exp_of(a, d, 1'b0)};
		chk({xvalid, program_page_select, sel, xaddr}, {v, pp, exp_of(a, d, 1'b1)});
		chk({xvalid_r, program_page_select_r, sel_r, xaddr_r}, w);
	endtask

	task automatic look(input logic [15:0] a, input logic d);
		i_core_model.acc(a, d);
		#1;
		both(a, d, 1'b1);
	endtask

	task wrap_up;
		$display("checks=%0d mismatches=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		repeat (4) @(posedge clk);
		#1;
		chk({xvalid, program_page_select, sel, xaddr}, {12'h0, 22'h3fffff});
		chk({xvalid_r, program_page_select_r, sel_r, xaddr_r}, {12'h0, 22'h3fffff});
		@(posedge clk);
		nrst <= 1'b1;
		look(16'h9000, 1'b0);
		put(3, 16'h0007);
		put(0, 16'h00ff);
		look(16'hbfff, 1'b0);
		put(1, 16'h00a5);
		look(16'h7abc, 1'b0);
		put(2, 16'h003c);
		look(16'h07ff, 1'b0);
		look(16'hff00, 1'b1);
		look(16'hff00, 1'b0);
		look(16'hfffe, 1'b0);
		put(5, 16'h8000);
		look(16'h8100, 1'b0);
		put(4, 16'h8000);
		look(16'h8100, 1'b0);
		look(16'h8300, 1'b0);
		// enable low: page write lost, outputs frozen at released bus
		@(posedge clk);
		ce <= 1'b0;
		i_core_model.put(0, 16'h0011);
		i_core_model.acc(16'hc123, 1'b0);
		#1;
		both(16'h7cff, 1'b0, 1'b0);
		@(posedge clk);
		ce <= 1'b1;
		look(16'h9000, 1'b0);
		put(4, 16'h0000);
		put(5, 16'h0800);
		for (int i = 0; i < 300; i++) begin
			r = $random(seed);
			if (r[17:16] == 2'h0) put(int'(r[19:18]), {8'h0, r[31:24]});
			look(r[15:0], r[21]);
		end
		// mid-run reset must drop pages and window enables again
		@(posedge clk);
		nrst <= 1'b0;
		{pp, dp, ep, en} = 27'h0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		look(16'h9000, 1'b0);
		look(16'h7abc, 1'b0);
		wrap_up();
	end

	// hang guard
	initial begin
		#400000;
		n_mismatch++;
		wrap_up();
	end
endmodule // tb

// ### src/page_map_pkg.sv
package page_map_pkg;
	// ------------------------------------------------------------
	// address map
	// ------------------------------------------------------------
	localparam logic [15:0] PROG_WIN_BASE = 16'h8000;
	localparam logic [15:0] PROG_WIN_LAST = 16'hbfff;
	localparam logic [15:0] UNPAGED_BASE = 16'hc000;
	localparam int WIN_LOW_BITS = 14;
	localparam int PAGE_BITS_FULL = 8;
	localparam int PAGE_BITS_REDUCED = 6;
	localparam int XADDR_BITS = 22;
	// ------------------------------------------------------------
	// default resource bases and sizes after reset
	// ------------------------------------------------------------
	localparam logic [15:0] REG_BASE_RST = 16'h0000;
	localparam logic [15:0] REG_SIZE = 16'h0200;
	localparam logic [15:0] VEC_BASE = 16'hff80;
	localparam logic [15:0] DBG_ROM_BASE = 16'hff00;
	localparam logic [15:0] RAM_BASE_RST = 16'h0800;
	localparam logic [15:0] RAM_SIZE = 16'h0400;
	localparam logic [15:0] EE_BASE_RST = 16'h1000;
	localparam logic [15:0] EE_SIZE = 16'h1000;
	localparam logic [15:0] FLASH_BASE_RST = 16'hc000;
	localparam logic [15:0] FLASH_SIZE = 16'h4000;
	localparam logic [15:0] DATA_WIN_BASE_RST = 16'h7000;
	localparam logic [15:0] DATA_WIN_SIZE_RST = 16'h1000;
	localparam logic [15:0] EXTRA_WIN_BASE_RST = 16'h0400;
	localparam logic [15:0] EXTRA_WIN_SIZE_RST = 16'h0400;
	localparam logic [7:0] PAGE_RST = 8'h00;
	// ------------------------------------------------------------
	// resource select codes
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		SEL_NONE, SEL_REGS, SEL_VECT, SEL_RAM, SEL_EE, SEL_FLASH,
		SEL_WINDOW
	} sel_t;
endpackage

// ### src/paged_memory_window_map.sv
`timescale 1ns/10ps
// Function
// - program window is fixed at 0x8000..0xbfff
// - each window has its own page select register, one page visible
// - 8-bit page select reaches 256 pages, each window-sized
// - reduced variant: 6-bit program page, 64 pages of 16 Kbytes
// - full variant has program, data and extra windows; latter configurable
// - reduced variant has no data or extra window logic
// - data and extra pages change only by ordinary core writes
// - 0xc000..0xffff is never page translated
// - overlap precedence: regs, vectors/debug rom, ram, eeprom, flash
// - windows rank below every on-chip resource
// - regs, ram, eeprom and flash start at default bases, relocatable by mapping writes; vectors/debug rom fixed
// - translation outside core; core only issues 16-bit addresses
// - outside enabled windows all expansion high lines drive one
// - translation disabled after reset until enables are written
module paged_memory_window_map import page_map_pkg::*; #(
	parameter bit FULL_VARIANT = 1'b1
) (
	// clock and reset
	input wire logic CLK_I,
	input wire logic NRST_I,
	input wire logic CE_I,
	// core access
	input wire logic [15:0] ADDR_I,
	input wire logic VALID_I,
	input wire logic DEBUG_ACTIVE_I,
	// page and window control writes
	input wire logic PROG_PAGE_WE_I,
	input wire logic DATA_PAGE_WE_I,
	input wire logic EXTRA_PAGE_WE_I,
	input wire logic [7:0] PAGE_WDATA_I,
	input wire logic ENABLE_WE_I,
	input wire logic [2:0] ENABLE_WDATA_I,
	// relocation writes
	input wire logic MAP_WE_I,
	input wire logic [2:0] MAP_SEL_I,
	input wire logic [15:0] MAP_WDATA_I,
	// translated access
	output logic [XADDR_BITS-1:0] XADDR_O,
	output logic [2:0] SEL_O,
	output logic XVALID_O,
	output logic [7:0] PROG_PAGE_O
);
	localparam int PW = FULL_VARIANT ? PAGE_BITS_FULL : PAGE_BITS_REDUCED;
	localparam int HI = XADDR_BITS - 16;

	// refuse a page wider than the expansion lines can carry
	if (PW > XADDR_BITS - WIN_LOW_BITS) begin : g_bad_width
		$error("page width exceeds expansion lines");
	end

	// ------------------------------------------------------------
	// page and mapping state
	// ------------------------------------------------------------
	logic [PW-1:0] program_page_select_reg;
	logic [2:0] win_en_reg;
	logic [15:0] reg_base_reg, ram_base_reg, ee_base_reg;
	logic [15:0] flash_base_reg;

	// core call/return paths arrive here as ordinary page writes
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			program_page_select_reg <= PW'(PAGE_RST);
			win_en_reg <= 3'h0;
			reg_base_reg <= REG_BASE_RST;
			ram_base_reg <= RAM_BASE_RST;
			ee_base_reg <= EE_BASE_RST;
			flash_base_reg <= FLASH_BASE_RST;
		end else if (CE_I) begin
			if (PROG_PAGE_WE_I)
				program_page_select_reg <= PAGE_WDATA_I[PW-1:0];
			if (ENABLE_WE_I)
				win_en_reg <= ENABLE_WDATA_I;
			if (MAP_WE_I && MAP_SEL_I == 3'h0)
				reg_base_reg <= MAP_WDATA_I;
			if (MAP_WE_I && MAP_SEL_I == 3'h1)
				ram_base_reg <= MAP_WDATA_I;
			if (MAP_WE_I && MAP_SEL_I == 3'h2)
				ee_base_reg <= MAP_WDATA_I;
			if (MAP_WE_I && MAP_SEL_I == 3'h3)
				flash_base_reg <= MAP_WDATA_I;
		end
	end

	// ------------------------------------------------------------
	// data and extra windows (full variant only)
	// ------------------------------------------------------------
	logic in_dwin, in_ewin;
	logic [7:0] data_page_w, extra_page_w;
	logic [15:0] dsize_w, esize_w;

	generate
		if (FULL_VARIANT) begin : g_full
			logic [7:0] data_page_select_reg, extra_page_select_reg;
			logic [15:0] dbase_reg, dsize_reg, ebase_reg, esize_reg;
			always_ff @(posedge CLK_I or negedge NRST_I) begin
				if (!NRST_I) begin
					data_page_select_reg <= PAGE_RST;
					extra_page_select_reg <= PAGE_RST;
					dbase_reg <= DATA_WIN_BASE_RST;
					dsize_reg <= DATA_WIN_SIZE_RST;
					ebase_reg <= EXTRA_WIN_BASE_RST;
					esize_reg <= EXTRA_WIN_SIZE_RST;
				end else if (CE_I) begin
					if (DATA_PAGE_WE_I)
						data_page_select_reg <= PAGE_WDATA_I;
					if (EXTRA_PAGE_WE_I)
						extra_page_select_reg <= PAGE_WDATA_I;
					if (MAP_WE_I && MAP_SEL_I == 3'h4)
						dbase_reg <= MAP_WDATA_I;
					if (MAP_WE_I && MAP_SEL_I == 3'h5)
						dsize_reg <= MAP_WDATA_I;
					if (MAP_WE_I && MAP_SEL_I == 3'h6)
						ebase_reg <= MAP_WDATA_I;
					if (MAP_WE_I && MAP_SEL_I == 3'h7)
						esize_reg <= MAP_WDATA_I;
				end
			end
			// windows may not reach the unpaged top block
			assign in_dwin = win_en_reg[1] && ADDR_I >= dbase_reg &&
				(ADDR_I - dbase_reg) < dsize_reg &&
				ADDR_I < UNPAGED_BASE;
			assign in_ewin = win_en_reg[2] && ADDR_I >= ebase_reg &&
				(ADDR_I - ebase_reg) < esize_reg &&
				ADDR_I < UNPAGED_BASE;
			assign data_page_w = data_page_select_reg;
			assign extra_page_w = extra_page_select_reg;
			assign dsize_w = dsize_reg;
			assign esize_w = esize_reg;
		end else begin : g_reduced
			assign in_dwin = 1'b0;
			assign in_ewin = 1'b0;
			assign data_page_w = 8'h00;
			assign extra_page_w = 8'h00;
			assign dsize_w = 16'h0000;
			assign esize_w = 16'h0000;
		end
	endgenerate

	// ------------------------------------------------------------
	// decode and precedence
	// ------------------------------------------------------------
	wire in_regs = (ADDR_I - reg_base_reg) < REG_SIZE &&
		ADDR_I >= reg_base_reg;
	wire in_vect = DEBUG_ACTIVE_I ? ADDR_I >= DBG_ROM_BASE :
		ADDR_I >= VEC_BASE;
	wire in_ram = ADDR_I >= ram_base_reg &&
		(ADDR_I - ram_base_reg) < RAM_SIZE;
	wire in_ee = ADDR_I >= ee_base_reg && (ADDR_I - ee_base_reg) < EE_SIZE;
	wire in_flash = ADDR_I >= flash_base_reg &&
		(ADDR_I - flash_base_reg) < FLASH_SIZE;
	wire in_pwin = win_en_reg[0] && ADDR_I >= PROG_WIN_BASE &&
		ADDR_I <= PROG_WIN_LAST;
	wire in_win = in_pwin || in_dwin || in_ewin;

	sel_t sel_w;
	assign sel_w = in_regs ? SEL_REGS :
		in_vect ? SEL_VECT :
		in_ram ? SEL_RAM :
		in_ee ? SEL_EE :
		in_flash ? SEL_FLASH :
		in_win ? SEL_WINDOW : SEL_NONE;

	// ------------------------------------------------------------
	// expanded address forming
	// ------------------------------------------------------------
	// window offset is bounded by size; sizes are powers of two
	function automatic logic [XADDR_BITS-1:0] page_addr(
		input logic [7:0] page, input logic [15:0] a,
		input logic [15:0] size);
		logic [XADDR_BITS-1:0] r;
		r = XADDR_BITS'(a & (size - 16'h0001));
		r = r | (XADDR_BITS'(page) * XADDR_BITS'(size));
		return r;
	endfunction

	logic [XADDR_BITS-1:0] xaddr_next;
	always_comb begin
		xaddr_next = {{HI{1'b1}}, ADDR_I};
		if (sel_w == SEL_WINDOW) begin
			if (in_pwin)
				xaddr_next = {(XADDR_BITS-WIN_LOW_BITS)'(program_page_select_reg),
					ADDR_I[WIN_LOW_BITS-1:0]};
			else if (in_dwin)
				xaddr_next = page_addr(data_page_w, ADDR_I, dsize_w);
			else
				xaddr_next = page_addr(extra_page_w, ADDR_I, esize_w);
		end
	end

	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			XADDR_O <= {XADDR_BITS{1'b1}};
			SEL_O <= SEL_NONE;
			XVALID_O <= 1'b0;
			PROG_PAGE_O <= 8'h00;
		end else if (CE_I) begin
			XADDR_O <= xaddr_next;
			SEL_O <= sel_w;
			XVALID_O <= VALID_I;
			PROG_PAGE_O <= 8'(program_page_select_reg);
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!NRST_I);

	chk_unpaged_top: assert property (CE_I && ADDR_I >= UNPAGED_BASE |=>
		XADDR_O == {{HI{1'b1}}, $past(ADDR_I)})
		else $error("unpaged block was translated");
	chk_prog_window: assert property (
		CE_I && sel_w == SEL_WINDOW && in_pwin |=>
		XADDR_O[WIN_LOW_BITS-1:0] == $past(ADDR_I[WIN_LOW_BITS-1:0]) &&
		XADDR_O[WIN_LOW_BITS+PW-1:WIN_LOW_BITS] ==
		$past(program_page_select_reg))
		else $error("program window address wrong");
	chk_high_ones: assert property (
		CE_I && sel_w != SEL_WINDOW |=> &XADDR_O[XADDR_BITS-1:16])
		else $error("high lines not one outside windows");
	chk_regs_first: assert property (
		CE_I && in_regs |=> SEL_O == SEL_REGS)
		else $error("registers lost precedence");
	chk_window_last: assert property (
		CE_I && (in_ram || in_flash) |=> SEL_O != SEL_WINDOW)
		else $error("window beat on-chip memory");
	chk_reset_off: assert property (
		$rose(NRST_I) |-> win_en_reg == 3'h0)
		else $error("translation enabled after reset");
	chk_page_hold: assert property (
		CE_I && !PROG_PAGE_WE_I |=> $stable(program_page_select_reg))
		else $error("program page changed without write");
	chk_pwin_range: assert property (
		CE_I && win_en_reg[0] && ADDR_I[15:14] == 2'b10 &&
		!(in_regs || in_vect || in_ram || in_ee || in_flash) |=>
		SEL_O == SEL_WINDOW)
		else $error("program window missed its fixed range");

	cov_prog_hit: cover property (CE_I && in_pwin && sel_w == SEL_WINDOW);
	cov_data_hit: cover property (CE_I && in_dwin && sel_w == SEL_WINDOW);
	cov_page_write: cover property (PROG_PAGE_WE_I ##1 in_pwin);
	cov_overlap: cover property (in_regs && in_ram);
endmodule // paged_memory_window_map
